/* design/sds_diag.v */
`timescale 1ns/1ns
`include "sds_regs.vh"

// Behaviour
// R1 - self-tests run at start-up and continuously during normal operation
// R2 - on failure, output is withheld or signalled via sent or pwm
// R3 - pwm error signalled by 0.5 or 99.5 percent duty
// R4 - overvoltage may be signalled by 2 percent duty, selectable
// R5 - all diagnostics readable as flags in two status registers
// R6 - primary bits 15,14,13: dsp check, nvm checksum, rom/ram checksum
// R7 - primary bits 12,11,10: junction temp, temp sensor, plate supply
// R8 - primary bit 9 set by hardware overtemperature above 180 C
// R9 - primary bit 7 adc stuck, bit 6 decimation overflow
// R10 - primary bit 5 upper field, bit 4 lower field threshold
// R11 - primary bit 3 position high, 2 position low, 1 plate current
// R12 - secondary bits 14 and 12 both flag general converter error
// R13 - secondary bit 11 undervoltage, bit 10 overvoltage
// R14 - secondary bit 9 analog, bit 8 digital supply out of range
// R15 - secondary low byte conditions reset the device immediately; here dev_reset_req rises two cycles after the fault, behind two sync stages
// R16 - secondary bits 7,6,5: uc self-test, rom opcode, memory opcode
// R17 - secondary bit 1 flags analog section error
// R18 - reserved bits read zero
// R19 - flags clear at reset and set in the fault's cycle; here they set three cycles after the fault, behind two sync stages
module sds_diag (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        startup_done,
  input  wire [15:0] fault_primary,
  input  wire [15:0] fault_secondary,
  input  wire        clr_flags,
  input  wire        out_is_pwm,
  input  wire        err_duty_high,
  input  wire        ovv_duty_en,
  input  wire [9:0]  pos_duty,
  input  wire        pos_valid,
  input  wire        rd_sel,
  output wire [15:0] rd_data,
  output wire [15:0] diag_status_primary,
  output wire [15:0] diag_status_secondary,
  output wire        selftest_run,
  output wire        sent_err,
  output wire        out_hold,
  output wire        dev_reset_req,
  output reg         pwm_out_ff
);

  //------------------------------------------------------------
  // self-test scheduling
  //------------------------------------------------------------
  reg        startup_ff;
  reg        startup_sync_ff;
  reg        startup_meta_ff;
  reg        normal_ff;

  // startup_done is from another block; synchronise it anyway
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      startup_meta_ff <= 1'b0;
      startup_sync_ff <= 1'b0;
      startup_ff      <= 1'b1;
      normal_ff       <= 1'b0;
    end else begin
      startup_meta_ff <= startup_done;
      startup_sync_ff <= startup_meta_ff;
      startup_ff      <= ~startup_sync_ff;
      normal_ff       <= startup_sync_ff;
    end
  end

  // both phase bits flip on one edge, so the checks never see a gap
  assign selftest_run = startup_ff | normal_ff; // [R1]

  //------------------------------------------------------------
  // fault input synchronisers
  //------------------------------------------------------------
  reg [15:0] fp_meta_ff;
  reg [15:0] fp_sync_ff;
  reg [15:0] fs_meta_ff;
  reg [15:0] fs_sync_ff;

  // check results may come from analogue comparators
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fp_meta_ff <= `SDS_STATUS_RESET;
      fp_sync_ff <= `SDS_STATUS_RESET;
      fs_meta_ff <= `SDS_STATUS_RESET;
      fs_sync_ff <= `SDS_STATUS_RESET;
    end else begin
      fp_meta_ff <= fault_primary;
      fp_sync_ff <= fp_meta_ff;
      fs_meta_ff <= fault_secondary;
      fs_sync_ff <= fs_meta_ff;
    end
  end

  //------------------------------------------------------------
  // status flags
  //------------------------------------------------------------
  wire [15:0] p_set;
  wire [15:0] s_set;
  wire [15:0] p_flag;
  wire [15:0] s_flag;

  // reserved positions are masked so they can never set
  assign p_set = fp_sync_ff & `SDS_PRIMARY_MASK;   // [R6] [R7] [R8]
  assign s_set = fs_sync_ff & `SDS_SECONDARY_MASK; // [R13] [R14] [R16]

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_flag
      // one sticky flag per condition, cleared by reset [R19]
      sds_flag u_p (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .set_in  (p_set[gi]),
        .clr_in  (clr_flags),
        .flag_ff (p_flag[gi])
      );
      sds_flag u_s (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .set_in  (s_set[gi]),
        .clr_in  (clr_flags),
        .flag_ff (s_flag[gi])
      );
    end
  endgenerate

  //------------------------------------------------------------
  // named conditions of the primary register
  //------------------------------------------------------------
  wire        dsp_check_flag;
  wire        nvm_crc_flag;
  wire        mem_crc_flag;
  wire        tj_range_flag;
  wire        tsens_flag;
  wire        plate_sup_flag;
  wire        hw_ot_flag;
  wire        adc_stuck_flag;
  wire        decim_flag;
  wire        field_high_flag;
  wire        field_low_flag;
  wire        pos_high_flag;
  wire        pos_low_flag;
  wire        plate_cur_flag;

  // one wire per check keeps the register layout readable
  assign dsp_check_flag  = p_flag[`SDS_P_DSP_CHECK];   // [R6]
  assign nvm_crc_flag    = p_flag[`SDS_P_NVM_CRC];
  assign mem_crc_flag    = p_flag[`SDS_P_MEM_CRC];
  assign tj_range_flag   = p_flag[`SDS_P_TJ_RANGE];    // [R7]
  assign tsens_flag      = p_flag[`SDS_P_TSENS_PLAUS];
  assign plate_sup_flag  = p_flag[`SDS_P_PLATE_SUP];
  assign hw_ot_flag      = p_flag[`SDS_P_HW_OVERTEMP]; // [R8]
  assign adc_stuck_flag  = p_flag[`SDS_P_ADC_STUCK];   // [R9]
  assign decim_flag      = p_flag[`SDS_P_DECIM_OVF];
  assign field_high_flag = p_flag[`SDS_P_FIELD_HIGH];  // [R10]
  assign field_low_flag  = p_flag[`SDS_P_FIELD_LOW];
  assign pos_high_flag   = p_flag[`SDS_P_POS_HIGH];    // [R11]
  assign pos_low_flag    = p_flag[`SDS_P_POS_LOW];
  assign plate_cur_flag  = p_flag[`SDS_P_PLATE_CUR];

  //------------------------------------------------------------
  // named conditions of the secondary register
  //------------------------------------------------------------
  wire        gpadc_a_flag;
  wire        gpadc_b_flag;
  wire        undervolt_flag;
  wire        overvolt_flag;
  wire        ana_volt_flag;
  wire        dig_volt_flag;
  wire        uc_selftest_flag;
  wire        uc_rom_flag;
  wire        uc_mem_flag;
  wire        analog_flag;
  wire        gpadc_err;

  // low-byte flags stay visible on the status port only
  assign gpadc_a_flag     = s_flag[`SDS_S_GPADC_A];
  assign gpadc_b_flag     = s_flag[`SDS_S_GPADC_B];
  assign undervolt_flag   = s_flag[`SDS_S_UNDERVOLT];   // [R13]
  assign overvolt_flag    = s_flag[`SDS_S_OVERVOLT];
  assign ana_volt_flag    = s_flag[`SDS_S_ANA_VOLT];    // [R14]
  assign dig_volt_flag    = s_flag[`SDS_S_DIG_VOLT];
  assign uc_selftest_flag = s_flag[`SDS_S_UC_SELFTEST]; // [R16]
  assign uc_rom_flag      = s_flag[`SDS_S_UC_ROM_OP];
  assign uc_mem_flag      = s_flag[`SDS_S_UC_MEM_OP];
  assign analog_flag      = s_flag[`SDS_S_ANALOG];      // [R17]

  // both converter-error positions mirror one another
  assign gpadc_err = gpadc_a_flag | gpadc_b_flag; // [R12]

  // one means condition present; reserved bits stay zero [R5] [R18]
  assign diag_status_primary = {
    dsp_check_flag,
    nvm_crc_flag,
    mem_crc_flag,
    tj_range_flag,
    tsens_flag,
    plate_sup_flag,
    hw_ot_flag,
    1'b0,
    adc_stuck_flag,
    decim_flag,
    field_high_flag,
    field_low_flag,
    pos_high_flag,
    pos_low_flag,
    plate_cur_flag,
    1'b0
  };
  assign diag_status_secondary = {
    1'b0,
    gpadc_err,
    1'b0,
    gpadc_err,          // [R12]
    undervolt_flag,
    overvolt_flag,
    ana_volt_flag,
    dig_volt_flag,
    uc_selftest_flag,
    uc_rom_flag,
    uc_mem_flag,
    3'b000,
    analog_flag,        // [R17]
    1'b0
  };

  // low-byte faults reset the part, so software sees them as zero
  assign dev_reset_req = |s_set[7:0]; // [R15]

  //------------------------------------------------------------
  // programming interface read port
  //------------------------------------------------------------
  reg [15:0] rd_data_ff;
  reg [15:0] nxt_rd_data;

  // secondary low byte is never readable here [R15]
  always @* begin
    if (rd_sel == `SDS_IDX_SECONDARY) begin
      nxt_rd_data = {diag_status_secondary[15:8], 8'h00};
    end else begin
      nxt_rd_data = diag_status_primary;
    end
  end

  // data follows the index one cycle late, traded for a clean word
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= `SDS_STATUS_RESET;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;

  //------------------------------------------------------------
  // error reporting on the output
  //------------------------------------------------------------
  wire any_err;
  wire ovv_only;

  // overvoltage alone may get its own level when enabled
  assign ovv_only = s_flag[`SDS_S_OVERVOLT] &
                    ~(|(diag_status_primary)) &
                    ~(|(diag_status_secondary &
                        ~(16'h0001 << `SDS_S_OVERVOLT)));
  assign any_err  = |diag_status_primary | |diag_status_secondary;

  // hide position values rather than emit a wrong one [R2]
  assign out_hold = any_err | ~pos_valid;
  assign sent_err = any_err & ~out_is_pwm; // [R2]

  //------------------------------------------------------------
  // pwm generator
  //------------------------------------------------------------
  reg [7:0] div_ff;
  reg [9:0] tick_ff;
  reg [9:0] duty_ff;
  reg [9:0] nxt_duty;
  wire      tick_en;

  assign tick_en = (div_ff == `SDS_PWM_DIV - 8'd1);

  // duty choice; error levels override the measured value
  always @* begin
    if (ovv_only && ovv_duty_en) begin
      nxt_duty = `SDS_DUTY_OVERVOLT;                    // [R4]
    end else if (any_err) begin
      nxt_duty = err_duty_high ? `SDS_DUTY_ERR_HIGH :
                                 `SDS_DUTY_ERR_LOW;     // [R3]
    end else if (pos_valid) begin
      nxt_duty = pos_duty;
    end else begin
      nxt_duty = `SDS_DUTY_ERR_LOW;
    end
  end

  // duty is latched at period start to avoid runt pulses
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff     <= 8'h00;
      tick_ff    <= 10'h000;
      duty_ff    <= `SDS_DUTY_ERR_LOW;
      pwm_out_ff <= 1'b0;
    end else begin
      div_ff <= tick_en ? 8'h00 : div_ff + 8'd1;
      if (tick_en) begin
        if (tick_ff == `SDS_PWM_PERIOD - 10'd1) begin
          tick_ff <= 10'h000;
          duty_ff <= nxt_duty;
        end else begin
          tick_ff <= tick_ff + 10'd1;
        end
      end
      pwm_out_ff <= out_is_pwm & (tick_ff < duty_ff); // [R3]
    end
  end

endmodule

/* design/sds_flag.v */
`timescale 1ns/1ns
// sticky flag: set wins over clear
module sds_flag (
  input  wire ref_clk,
  input  wire rst_n,
  input  wire set_in,
  input  wire clr_in,
  output reg  flag_ff
);
  // a fault in the clearing cycle is kept
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= 1'b0;
    end else if (set_in) begin
      flag_ff <= 1'b1;
    end else if (clr_in) begin
      flag_ff <= 1'b0;
    end
  end
endmodule

/* design/sds_regs.vh */
`ifndef SDS_REGS_VH
`define SDS_REGS_VH
// register indices on the programming interface
`define SDS_IDX_PRIMARY     1'b0
`define SDS_IDX_SECONDARY   1'b1
// primary status bit positions
`define SDS_P_DSP_CHECK     15
`define SDS_P_NVM_CRC       14
`define SDS_P_MEM_CRC       13
`define SDS_P_TJ_RANGE      12
`define SDS_P_TSENS_PLAUS   11
`define SDS_P_PLATE_SUP     10
`define SDS_P_HW_OVERTEMP   9
`define SDS_P_ADC_STUCK     7
`define SDS_P_DECIM_OVF     6
`define SDS_P_FIELD_HIGH    5
`define SDS_P_FIELD_LOW     4
`define SDS_P_POS_HIGH      3
`define SDS_P_POS_LOW       2
`define SDS_P_PLATE_CUR     1
// secondary status bit positions
`define SDS_S_GPADC_A       14
`define SDS_S_GPADC_B       12
`define SDS_S_UNDERVOLT     11
`define SDS_S_OVERVOLT      10
`define SDS_S_ANA_VOLT      9
`define SDS_S_DIG_VOLT      8
`define SDS_S_UC_SELFTEST   7
`define SDS_S_UC_ROM_OP     6
`define SDS_S_UC_MEM_OP     5
`define SDS_S_ANALOG        1
// writable-bit masks; reserved bits read zero
`define SDS_PRIMARY_MASK    16'hfefe
`define SDS_SECONDARY_MASK  16'h5fe2
`define SDS_STATUS_RESET    16'h0000
// pwm duty in tenths of a percent, period 1000 ticks
`define SDS_PWM_PERIOD      10'd1000
`define SDS_DUTY_ERR_LOW    10'd5
`define SDS_DUTY_ERR_HIGH   10'd995
`define SDS_DUTY_OVERVOLT   10'd20
// cycles of ref_clk per pwm tick
`define SDS_PWM_DIV         8'd10
`endif

/* tb/sds_diag_monitor.sv */
`timescale 1ns/1ns
// port watcher: reserved bits, read mux, latency and stickiness
module sds_diag_mon (
  input wire        ref_clk,
  input wire        rst_n,
  input wire [15:0] fault_primary,
  input wire [15:0] fault_secondary,
  input wire        clr_flags,
  input wire        out_is_pwm,
  input wire        pos_valid,
  input wire        rd_sel,
  input wire [15:0] rd_data,
  input wire [15:0] diag_status_primary,
  input wire [15:0] diag_status_secondary,
  input wire        selftest_run,
  input wire        sent_err,
  input wire        out_hold,
  input wire        dev_reset_req
);
  wire [7:0] sec_hi;
  assign sec_hi = diag_status_secondary[15:8];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_rsv_pri: assert property (
    (diag_status_primary & 16'h0101) == 16'h0000) else $error("rsv pri");
  a_rsv_sec: assert property (
    (diag_status_secondary & 16'ha01d) == 16'h0000) else $error("rsv sec");
  a_read_mux: assert property (
    1'b1 |=> rd_data == ($past(rd_sel) ? {$past(sec_hi), 8'h00}
                                       : $past(diag_status_primary)))
    else $error("read mux");
  // two sync stages plus the flag itself, so four samples suffice
  a_flag_set: assert property (
    (fault_primary[9] && !clr_flags) [*4] |-> diag_status_primary[9])
    else $error("flag late");
  a_flag_hold: assert property (
    diag_status_primary[9] && !clr_flags |=> diag_status_primary[9])
    else $error("flag lost");
  a_gp_pair: assert property (
    diag_status_secondary[14] == diag_status_secondary[12])
    else $error("pair split");
  a_reset_req: assert property (
    fault_secondary[7] [*3] |-> dev_reset_req) else $error("no reset");
  a_sent_err: assert property (
    (|diag_status_primary) && !out_is_pwm |-> sent_err)
    else $error("sent err");
  a_out_hold: assert property (
    !pos_valid |-> out_hold) else $error("no hold");
  a_test_on: assert property (
    selftest_run) else $error("tests off");
  c_reset: cover property (dev_reset_req);
  c_sent: cover property (sent_err);
  c_ovt: cover property (diag_status_primary[9]);
endmodule

/* tb/sds_pwm_rx.sv */
`timescale 1ns/1ns
// control unit receiving pwm: measures each high pulse in ticks
module sds_pwm_rx (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       pwm_in,
  output reg  [9:0] duty_ticks
);
  int cnt;
  // judged at the falling edge; rounding absorbs a cycle of skew
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      duty_ticks <= 10'h000;
    end else if (pwm_in) begin
      cnt <= cnt + 1;
    end else begin
      if (cnt != 0) duty_ticks <= 10'((cnt + 5) / 10);
      cnt <= 0;
    end
  end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ns
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin \
  mismatches++; $display("unexpected %s exp %h got %h", nm, e, s); end end
module tb;
  typedef struct {int what; logic [15:0] v;} note_t;
  reg        ref_clk = 0, rst_n = 0, startup_done = 0, clr_flags = 0;
  reg        out_is_pwm = 1, err_duty_high = 0, ovv_duty_en = 0;
  reg        pos_valid = 1, rd_sel = 0;
  reg [15:0] fp = 16'h0000, fs = 16'h0000;
  reg [9:0]  pos_duty = 10'd300;
  wire [15:0] rd_data, st_p, st_s;
  wire       selftest_run, sent_err, out_hold, dev_reset_req, pwm_out;
  wire [9:0] duty_ticks;
  int        mismatches = 0, n_checks = 0, i;
  note_t     q[$], nt;
  logic [15:0] g;
  event      ev;
  sds_diag i_dut (.ref_clk, .rst_n, .startup_done, .fault_primary(fp),
    .fault_secondary(fs), .clr_flags, .out_is_pwm, .err_duty_high,
    .ovv_duty_en, .pos_duty, .pos_valid, .rd_sel, .rd_data,
    .diag_status_primary(st_p), .diag_status_secondary(st_s),
    .selftest_run, .sent_err, .out_hold, .dev_reset_req,
    .pwm_out_ff(pwm_out));
  sds_pwm_rx i_rx (.ref_clk, .rst_n, .pwm_in(pwm_out), .duty_ticks);
  initial forever #50 ref_clk = ~ref_clk;
  task step(int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask
  task note(int w, logic [15:0] v);
    q.push_back('{w, v});
    ->ev;
  endtask
  task end_sim;
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // oldest note against what the outputs show now
  initial forever begin
    @(ev);
    while (q.size() != 0) begin
      nt = q.pop_front();
      case (nt.what)
        0: `CHK("rd_data", nt.v, rd_data)
        1: `CHK("dev_reset_req", nt.v[0], dev_reset_req)
        3: `CHK("sent_err", nt.v[0], sent_err)
        4: `CHK("out_hold", nt.v[0], out_hold)
        default: `CHK("duty", nt.v[9:0], duty_ticks)
      endcase
    end
  end
  initial begin
    void'($urandom(32'h753e91b9));
    step(16);
    rst_n = 1;
    startup_done = 1;
    step(2);
    note(0, 16'h0000);
    rd_sel = 1;
    step(1);
    note(0, 16'h0000);
    // normal, lone overvoltage, error high, error low; flags stay set
    for (i = 0; i < 4; i++) begin
      fs = (i == 1) ? 16'h0400 : 16'h0000;
      fp = (i > 1) ? 16'h8000 : 16'h0000;
      ovv_duty_en = (i == 1);
      err_duty_high = (i == 2);
      step(21000);
      note(2, (i == 0) ? 300 : (i == 1) ? 20 : (i == 2) ? 995 : 5);
    end
    // random faults, cleared for four cycles with inputs low; set still wins for the first two, until the sync stages drain
    repeat (9) begin
      clr_flags = 1;
      fp = 16'h0000;
      fs = 16'h0000;
      step(4);
      clr_flags = 0;
      fp = 16'($urandom);
      fs = 16'($urandom);
      out_is_pwm = 1'($urandom);
      pos_valid = 1'($urandom);
      step(4);
      rd_sel = 0;
      step(1);
      note(0, fp & 16'hfefe);
      g = (fs[14] | fs[12]) ? 16'h5000 : 16'h0000;
      rd_sel = 1;
      step(1);
      note(0, g | (fs & 16'h0f00));
      note(1, {15'h0000, |(fs & 16'h00e2)});
      g[0] = |(fp & 16'hfefe) | |(fs & 16'h5fe2);
      note(3, {15'h0000, g[0] & ~out_is_pwm});
      note(4, {15'h0000, g[0] | ~pos_valid});
    end
    end_sim;
  end
  initial begin
    #(100 * 95000);
    mismatches++;
    end_sim;
  end
endmodule
bind sds_diag sds_diag_mon i_mon (.ref_clk, .rst_n, .fault_primary,
  .fault_secondary, .clr_flags, .out_is_pwm, .pos_valid, .rd_sel,
  .rd_data, .diag_status_primary, .diag_status_secondary,
  .selftest_run, .sent_err, .out_hold, .dev_reset_req);
